// ==== rtl/psdf_pin_sync.sv ====
// Pin synchronisers and bus condition detection for the I2C lines
`timescale 1ns/1ps
module psdf_pin_sync (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl,
	output logic sda,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_det,
	output logic stop_det
);
	logic scl_meta;
	logic sda_meta;
	logic scl_d;
	logic sda_d;

	// Two stages per pin, then one more to find edges
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			scl_meta <= 1'b1;
			sda_meta <= 1'b1;
			scl <= 1'b1;
			sda <= 1'b1;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else if (clk_en)
		begin
			scl_meta <= scl_in;
			sda_meta <= sda_in;
			scl <= scl_meta;
			sda <= sda_meta;
			scl_d <= scl;
			sda_d <= sda;
		end

	// Start and stop are data edges while the clock stays high
	assign scl_rise = scl & ~scl_d;
	assign scl_fall = ~scl & scl_d;
	assign start_det = scl & scl_d & sda_d & ~sda;
	assign stop_det = scl & scl_d & ~sda_d & sda;
endmodule

// ==== rtl/psdf_pkg.sv ====
// Shared types of the pressure data fetch block
package psdf_pkg;
	typedef enum logic [1:0] {
		PSDF_ST_FRESH = 2'h0,
		PSDF_ST_INVALID = 2'h1,
		PSDF_ST_STALE = 2'h2,
		PSDF_ST_DIAG = 2'h3
	} psdf_status_t;
	typedef enum logic [3:0] {
		SEQ_INIT = 4'h1,
		SEQ_MEAS = 4'h2,
		SEQ_PDOWN = 4'h4,
		SEQ_SLEEP = 4'h8
	} psdf_seq_state_t;
	typedef enum logic [6:0] {
		I2C_IDLE = 7'h01,
		I2C_ADDR = 7'h02,
		I2C_AACK = 7'h04,
		I2C_TX = 7'h08,
		I2C_TACK = 7'h10,
		I2C_RX = 7'h20,
		I2C_RACK = 7'h40
	} psdf_i2c_state_t;
endpackage

// ==== rtl/psdf_regs.svh ====
// Register map, field positions, reset values and timing counts
//
// Operation
// - Keep sending packet bytes until the controller ends the read.
// - Three bytes: two pressure bytes with status on top, one 8-bit temp byte.
// - A fourth byte carries the rest of the 11-bit temperature.
// - Low five bits of byte four are undefined; controller masks them.
// - Pressure is 14 bits unsigned; minimum 1638, span 13107 counts.
// - Temperature code spans 165 degrees from minus 40 at zero.
// - Two status bits sit in the top of the first packet byte.
// - Status 00 on first fetch after a measurement, 10 afterwards.
// - Status 01 for invalid state, 11 for a diagnostic fault.
// - Fetches before or during the first measurement report stale.
// - Power-up initializes and measures, active about 2.8 ms.
// - Update mode: 255 pressure-only cycles, then a full 256th one.
// - Temperature plus offset zeroing measurement takes about 1.5 ms.
// - Power-down interval is one of 0, 1, 6 or 32 ms.
// - After a fetch returned data, status turns stale until new result.
// - Sleep: address-only read then stop wakes a full measurement.
// - Sleep: address-only write wakes a pressure-only measurement.
`ifndef PSDF_REGS_SVH
`define PSDF_REGS_SVH
`define PSDF_ADDR_CTRL 4'h0
`define PSDF_ADDR_MEAS 4'h4
`define PSDF_ADDR_STAT 4'h8
`define PSDF_ADDR_RES 4'hC
`define PSDF_CTRL_SLEEP 0
`define PSDF_CTRL_PD_LO 1
`define PSDF_CTRL_PD_HI 2
`define PSDF_CTRL_DIAG 3
`define PSDF_CTRL_INVAL 4
`define PSDF_CTRL_MASK 32'h0000_001F
`define PSDF_MEAS_MASK 32'h07FF_3FFF
`define PSDF_CTRL_RESET 32'h0000_0000
`define PSDF_MEAS_RESET 32'h0000_0000
`define PSDF_I2C_ADDR 7'h28
`define PSDF_PRESS_RUN 8'hFF
`define PSDF_CLK_MHZ 50
`define PSDF_T_INIT_US 2800
`define PSDF_T_SLP_INIT_US 1800
`define PSDF_T_FULL_US 1500
`define PSDF_T_PRESS_US 500
`define PSDF_T_PD1_US 1000
`define PSDF_T_PD2_US 6000
`define PSDF_T_PD3_US 32000
`define PSDF_CYC(us) ((us) * `PSDF_CLK_MHZ)
`endif

// ==== rtl/psdf_seq_if.sv ====
// Requests and results between the top and the measurement sequencer
`timescale 1ns/1ps
interface psdf_seq_if;
	logic sleep_mode;
	logic [1:0] pd_sel;
	logic full_req;
	logic press_req;
	logic result_write;
	logic result_full;
	logic busy;
	logic [7:0] press_cnt;
	modport top (
		output sleep_mode, pd_sel, full_req, press_req,
		input result_write, result_full, busy, press_cnt
	);
	modport seq (
		input sleep_mode, pd_sel, full_req, press_req,
		output result_write, result_full, busy, press_cnt
	);
endinterface

// ==== rtl/psdf_sequencer.sv ====
// Measurement sequencing for update and sleep modes
`timescale 1ns/1ps
`include "psdf_regs.svh"
module psdf_sequencer #(
	parameter int unsigned INIT_CYC = 1,
	parameter int unsigned SLP_INIT_CYC = 1,
	parameter int unsigned FULL_CYC = 1,
	parameter int unsigned PRESS_CYC = 1,
	parameter int unsigned PD1_CYC = 1,
	parameter int unsigned PD2_CYC = 1,
	parameter int unsigned PD3_CYC = 1
)(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	psdf_seq_if.seq bus
);
	import psdf_pkg::*;
	psdf_seq_state_t state;
	logic [31:0] cnt;
	logic [31:0] limit;
	logic full;
	logic done;

	// Length of the current phase
	always_comb
	begin
		case (state)
		SEQ_INIT: limit = bus.sleep_mode ? 32'(SLP_INIT_CYC) : 32'(INIT_CYC);
		SEQ_MEAS: limit = full ? 32'(FULL_CYC) : 32'(PRESS_CYC);
		SEQ_PDOWN:
			case (bus.pd_sel)
			2'h1: limit = 32'(PD1_CYC);
			2'h2: limit = 32'(PD2_CYC);
			2'h3: limit = 32'(PD3_CYC);
			default: limit = 32'h0000_0000;
			endcase
		default: limit = 32'h0000_0000;
		endcase
	end

	// A zero-length power-down still costs one cycle
	assign done = (cnt + 32'h0000_0001) >= limit;
	assign bus.busy = (state == SEQ_INIT) | (state == SEQ_MEAS);

	// Phase walk and result strobe
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			state <= SEQ_INIT;
			cnt <= 32'h0000_0000;
			full <= 1'b1;
			bus.result_write <= 1'b0;
			bus.result_full <= 1'b0;
			bus.press_cnt <= 8'h00;
		end
		else if (clk_en)
		begin
			bus.result_write <= 1'b0;
			cnt <= cnt + 32'h0000_0001;
			case (state)
			SEQ_INIT:
				if (done)
				begin
					cnt <= 32'h0000_0000;
					bus.result_write <= ~bus.sleep_mode;
					bus.result_full <= 1'b1;
					bus.press_cnt <= 8'h00;
					state <= bus.sleep_mode ? SEQ_SLEEP : SEQ_PDOWN;
				end
			SEQ_MEAS:
				if (done)
				begin
					cnt <= 32'h0000_0000;
					bus.result_write <= 1'b1;
					bus.result_full <= full;
					bus.press_cnt <= full ? 8'h00 : bus.press_cnt + 8'h01;
					state <= bus.sleep_mode ? SEQ_SLEEP : SEQ_PDOWN;
				end
			SEQ_PDOWN:
				if (bus.sleep_mode)
				begin
					cnt <= 32'h0000_0000;
					state <= SEQ_SLEEP;
				end
				else if (done)
				begin
					cnt <= 32'h0000_0000;
					full <= bus.press_cnt == `PSDF_PRESS_RUN;
					state <= SEQ_MEAS;
				end
			SEQ_SLEEP:
			begin
				cnt <= 32'h0000_0000;
				if (bus.full_req || !bus.sleep_mode)
				begin
					full <= 1'b1;
					state <= SEQ_MEAS;
				end
				else if (bus.press_req)
				begin
					full <= 1'b0;
					state <= SEQ_MEAS;
				end
			end
			default: state <= SEQ_INIT;
			endcase
		end
endmodule

// ==== rtl/psdf_top.sv ====
// Top of the pressure data fetch block: bus slave, I2C target, packet
`timescale 1ns/1ps
`include "psdf_regs.svh"
module psdf_top #(
	parameter int unsigned INIT_CYC = `PSDF_CYC(`PSDF_T_INIT_US),
	parameter int unsigned SLP_INIT_CYC = `PSDF_CYC(`PSDF_T_SLP_INIT_US),
	parameter int unsigned FULL_CYC = `PSDF_CYC(`PSDF_T_FULL_US),
	parameter int unsigned PRESS_CYC = `PSDF_CYC(`PSDF_T_PRESS_US),
	parameter int unsigned PD1_CYC = `PSDF_CYC(`PSDF_T_PD1_US),
	parameter int unsigned PD2_CYC = `PSDF_CYC(`PSDF_T_PD2_US),
	parameter int unsigned PD3_CYC = `PSDF_CYC(`PSDF_T_PD3_US),
	parameter logic [6:0] DEV_ADDR = `PSDF_I2C_ADDR
)(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import psdf_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [31:0] ctrl;
	logic [31:0] meas;
	logic [31:0] rd_mux;
	logic [13:0] res_p;
	logic [10:0] res_t;
	logic fresh;
	logic fetch_done;
	logic newer;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	psdf_i2c_state_t state;
	logic [3:0] bits;
	logic [7:0] shift;
	logic [7:0] tx_sh;
	logic [2:0] nbytes;
	logic [1:0] byte_idx;
	logic acked;
	logic rd_txn;
	logic wr_txn;
	logic addr_done;
	logic addr_hit;
	logic next_sda_oe;
	logic [7:0] pkt [0:3];
	psdf_status_t cur_status;
	psdf_seq_if sq();

	// ************************************************************
	// Helpers
	// ************************************************************

	// Fault codes outrank data age; invalid outranks diagnostic
	function automatic psdf_status_t status_of(
		input logic inval,
		input logic diag,
		input logic fr,
		input logic busy_slp
	);
		psdf_status_t s;
		if (inval)
			s = PSDF_ST_INVALID;
		else if (diag)
			s = PSDF_ST_DIAG;
		else if (fr && !busy_slp)
			s = PSDF_ST_FRESH;
		else
			s = PSDF_ST_STALE;
		return s;
	endfunction

	// Byte-lane merge of a bus write
	function automatic logic [31:0] be_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] be
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		return r;
	endfunction

	// ************************************************************
	// Submodules
	// ************************************************************

	// Pins are foreign to clk, so both pass two stages first
	psdf_pin_sync u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl(scl_s),
		.sda(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det)
	);

	psdf_sequencer #(
		.INIT_CYC(INIT_CYC),
		.SLP_INIT_CYC(SLP_INIT_CYC),
		.FULL_CYC(FULL_CYC),
		.PRESS_CYC(PRESS_CYC),
		.PD1_CYC(PD1_CYC),
		.PD2_CYC(PD2_CYC),
		.PD3_CYC(PD3_CYC)
	) u_seq (
		.clk(clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.bus(sq)
	);

	assign sq.sleep_mode = ctrl[`PSDF_CTRL_SLEEP];
	assign sq.pd_sel = ctrl[`PSDF_CTRL_PD_HI:`PSDF_CTRL_PD_LO];

	// ************************************************************
	// Result store and data age
	// ************************************************************

	// Stale while a sleep-mode measurement is still running
	assign cur_status = status_of(ctrl[`PSDF_CTRL_INVAL],
		ctrl[`PSDF_CTRL_DIAG], fresh, sq.sleep_mode & sq.busy);

	// Whole result replaced in one edge; pressure-only keeps old temp
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			res_p <= 14'h0000;
			res_t <= 11'h000;
		end
		else if (clk_en && sq.result_write)
		begin
			res_p <= meas[13:0];
			if (sq.result_full)
				res_t <= meas[26:16];
		end

	// New result beats a fetch ending in the same cycle; a fetch whose
	// snapshot is older than the latest result leaves that result fresh
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			fresh <= 1'b0;
			newer <= 1'b0;
		end
		else if (clk_en)
		begin
			if (sq.result_write)
				fresh <= 1'b1;
			else if (fetch_done && !newer)
				fresh <= 1'b0;
			if (sq.result_write)
				newer <= 1'b1;
			else if (addr_hit)
				newer <= 1'b0;
		end

	// Packet frozen at address match, so bytes never mix results
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			pkt[0] <= 8'h00;
			pkt[1] <= 8'h00;
			pkt[2] <= 8'h00;
			pkt[3] <= 8'h00;
		end
		else if (clk_en && addr_hit)
		begin
			pkt[0] <= {cur_status, res_p[13:8]};
			pkt[1] <= res_p[7:0];
			pkt[2] <= res_t[10:3];
			pkt[3] <= {res_t[2:0], 5'h00};
		end

	// ************************************************************
	// I2C target
	// ************************************************************
	assign addr_done = (state == I2C_ADDR) && scl_fall && (bits == 4'h8);
	assign addr_hit = addr_done && (shift[7:1] == DEV_ADDR);
	assign byte_idx = (nbytes > 3'h3) ? 2'h3 : nbytes[1:0];

	// Bit engine; a start anywhere restarts address reception
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			state <= I2C_IDLE;
			bits <= 4'h0;
			shift <= 8'h00;
			tx_sh <= 8'hFF;
			nbytes <= 3'h0;
			acked <= 1'b0;
			rd_txn <= 1'b0;
			wr_txn <= 1'b0;
		end
		else if (clk_en)
		begin
			if (start_det)
			begin
				state <= I2C_ADDR;
				bits <= 4'h0;
				nbytes <= 3'h0;
				rd_txn <= 1'b0;
				wr_txn <= 1'b0;
			end
			else if (stop_det)
			begin
				state <= I2C_IDLE;
				rd_txn <= 1'b0;
				wr_txn <= 1'b0;
			end
			else
				case (state)
				I2C_ADDR:
					if (scl_rise)
					begin
						shift <= {shift[6:0], sda_s};
						bits <= bits + 4'h1;
					end
					else if (addr_done)
					begin
						bits <= 4'h0;
						state <= addr_hit ? I2C_AACK : I2C_IDLE;
						rd_txn <= addr_hit & shift[0];
						wr_txn <= addr_hit & ~shift[0];
					end
				I2C_AACK:
					if (scl_fall)
					begin
						state <= rd_txn ? I2C_TX : I2C_RX;
						tx_sh <= pkt[0];
					end
				I2C_TX:
					if (scl_fall)
					begin
						if (bits == 4'h7)
						begin
							bits <= 4'h0;
							state <= I2C_TACK;
						end
						else
						begin
							bits <= bits + 4'h1;
							tx_sh <= {tx_sh[6:0], 1'b1};
						end
					end
				I2C_TACK:
					if (scl_rise)
					begin
						acked <= ~sda_s;
						if (nbytes != 3'h7)
							nbytes <= nbytes + 3'h1;
					end
					else if (scl_fall)
					begin
						state <= acked ? I2C_TX : I2C_IDLE;
						tx_sh <= pkt[byte_idx];
					end
				I2C_RX:
					if (scl_rise)
						bits <= bits + 4'h1;
					else if (scl_fall && bits == 4'h8)
					begin
						bits <= 4'h0;
						state <= I2C_RACK;
					end
				I2C_RACK:
					if (scl_fall)
						state <= I2C_RX;
				default: state <= I2C_IDLE;
				endcase
		end

	// Open-drain drive: only ever pull low
	always_comb
	begin
		case (state)
		I2C_AACK: next_sda_oe = 1'b1;
		I2C_RACK: next_sda_oe = 1'b1;
		I2C_TX: next_sda_oe = ~tx_sh[7];
		default: next_sda_oe = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end
		else if (clk_en)
		begin
			sda_oe <= next_sda_oe;
			sda_out <= 1'b0;
		end

	// Transfer outcomes, judged at the stop condition
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			sq.full_req <= 1'b0;
			sq.press_req <= 1'b0;
			fetch_done <= 1'b0;
		end
		else if (clk_en)
		begin
			sq.full_req <= stop_det && rd_txn && nbytes == 3'h0;
			sq.press_req <= stop_det && wr_txn;
			fetch_done <= stop_det && rd_txn && nbytes != 3'h0;
		end

	// ************************************************************
	// Avalon-MM slave, one wait state per access
	// ************************************************************
	always_comb
	begin
		case (avs_address)
		`PSDF_ADDR_CTRL: rd_mux = ctrl;
		`PSDF_ADDR_MEAS: rd_mux = meas;
		`PSDF_ADDR_STAT: rd_mux = {19'h00000, state != I2C_IDLE,
			sq.press_cnt, sq.busy, fresh, cur_status};
		`PSDF_ADDR_RES: rd_mux = {5'h00, res_t, 2'h0, res_p};
		default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Write lands on the edge the master sees waitrequest low
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			ctrl <= `PSDF_CTRL_RESET;
			meas <= `PSDF_MEAS_RESET;
		end
		else if (clk_en)
		begin
			avs_waitrequest <= ~(avs_waitrequest & (avs_read | avs_write));
			if (avs_waitrequest && avs_read)
				avs_readdata <= rd_mux;
			if (!avs_waitrequest && avs_write)
				case (avs_address)
				`PSDF_ADDR_CTRL: ctrl <= be_merge(ctrl, avs_writedata,
					avs_byteenable) & `PSDF_CTRL_MASK;
				`PSDF_ADDR_MEAS: meas <= be_merge(meas, avs_writedata,
					avs_byteenable) & `PSDF_MEAS_MASK;
				default: ;
				endcase
		end
endmodule

// ==== test/psdf_checker.sv ====
// Port-level assertion checker for the pressure data fetch top
`timescale 1ns/1ps
module psdf_checker (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	// ****
	// Bus slave and pin relations
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// Any pending bus request
	wire req = avs_read | avs_write;
	AST_REQ_ANSWER: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered next cycle");
	AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_IDLE_WAIT: assert property (!req && avs_waitrequest |=> avs_waitrequest)
		else $error("answer without a request");
	// Read data may only move when a read is answered
	AST_RDATA_HOLD: assert property ($changed(avs_readdata) |-> !avs_waitrequest && $past(avs_read))
		else $error("read data changed outside a read");
	AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
		else $error("unaligned address read non-zero");
	// Drive changes only while the clock line is low, else a false start or stop
	AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !$past(scl_in))
		else $error("data drive changed with clock high");
	AST_OPEN_DRAIN: assert property (!sda_out)
		else $error("data pin driven high");
	AST_STOP_QUIET: assert property (scl_in && $past(scl_in) &&
		$rose(sda_in) |=> !sda_oe [*8])
		else $error("data driven after stop");
	cover property (avs_read && !avs_waitrequest);
	cover property (avs_write && !avs_waitrequest);
	cover property ($rose(sda_oe));
endmodule

// ==== test/psdf_i2c_ctl.sv ====
// Behavioural I2C controller that fetches packets from the block
`timescale 1ns/1ps
`include "psdf_regs.svh"
module psdf_i2c_ctl (
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	// ****
	// Bus primitives, one clock period of 160 ns
	// ****
	// Clock stands high and data released between frames
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Data set early in the low phase, sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		#20 sda_low = !b;
		#60 scl = 1'b1;
		#60 r = sda;
		#20 scl = 1'b0;
	endtask
	// Address phase, then n bytes; n of 0 gives an address-only frame
	task automatic xfer(input logic rd, input int n, output logic [31:0] pk,
		output logic ack);
		logic [7:0] a;
		logic r;
		a = {`PSDF_I2C_ADDR, rd};
		pk = 32'h0;
		#7 sda_low = 1'b1;
		#80 scl = 1'b0;
		for (int i = 7; i >= 0; i--)
			bit_io(a[i], r);
		bit_io(1'b1, ack);
		for (int k = 0; k < n; k++)
		begin
			for (int i = 0; i < 8; i++)
			begin
				bit_io(1'b1, r);
				pk = {pk[30:0], r};
			end
			bit_io(k == n - 1, r);
		end
		#20 sda_low = 1'b1;
		#60 scl = 1'b1;
		#80 sda_low = 1'b0;
	endtask
endmodule

// ==== test/psdf_top_tb.sv ====
// Self-checking testbench of the pressure data fetch block
`timescale 1ns/1ps
`include "psdf_regs.svh"
module psdf_top_tb;
	import psdf_pkg::*;
	// ****
	// Clock, reset and instances
	// ****
	// Shortened counts keep the run brief; expectations use these
	localparam int PRESS = 40;
	localparam int PD1 = 20;
	localparam int PD2 = 60;
	localparam int PD3 = 120;
	logic clk, arst_n, scl, m_low, sda_oe, sda_out, rd, wr, wt;
	logic [3:0] addr, be;
	logic [31:0] wdata, rdata, q, pk;
	int error_cnt, cmp_count;
	// Open-drain line with pull-up
	wire sda = !(sda_oe || m_low);
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	psdf_top #(.INIT_CYC(200), .SLP_INIT_CYC(150), .FULL_CYC(100),
		.PRESS_CYC(PRESS), .PD1_CYC(PD1), .PD2_CYC(PD2), .PD3_CYC(PD3))
		u_psdf_top (.clk(clk), .arst_n(arst_n), .clk_en(1'b1),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_byteenable(be),
		.avs_readdata(rdata), .avs_waitrequest(wt));
	psdf_i2c_ctl u_psdf_i2c_ctl (.scl(scl), .sda_low(m_low), .sda(sda));
	// ****
	// Shared tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One bus access; request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		while (wt !== 1'b0)
			@(posedge clk);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	// Ends on a clock edge so the next bus request starts right after one
	task automatic fetch(input logic r, input int n);
		logic ack;
		@(posedge clk);
		u_psdf_i2c_ctl.xfer(r, n, pk, ack);
		check({31'h0, ack}, 32'h0);
		@(posedge clk);
	endtask
	function automatic logic [31:0] pkt(input logic [1:0] st,
		input logic [13:0] p, input logic [10:0] t);
		return {st, p, t[10:3], t[2:0], 5'h00};
	endfunction
	// Fetch n bytes; the undefined low bits of byte four are masked
	task automatic fetch_chk(input int n, input logic [1:0] st,
		input logic [13:0] p, input logic [10:0] t);
		fetch(1'b1, n);
		if (n == 4)
			pk[4:0] = 5'h00;
		check(pk, pkt(st, p, t) >> (8 * (4 - n)));
	endtask
	task automatic wait_cnt(output longint t);
		logic [7:0] v;
		bus(1'b0, `PSDF_ADDR_STAT, 32'h0);
		v = q[11:4];
		for (int n = 0; n < 400 && q[11:4] === v; n++)
			bus(1'b0, `PSDF_ADDR_STAT, 32'h0);
		t = $time;
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		fetch(1'b1, 2);
		check(32'(pk[15:14]), 32'(PSDF_ST_STALE));
		bus(1'b0, `PSDF_ADDR_CTRL, 32'h0);
		check(q, `PSDF_CTRL_RESET);
		bus(1'b1, 4'h2, 32'hFFFF_FFFF);
		bus(1'b0, 4'h2, 32'h0);
		check(q, 32'h0);
		bus(1'b1, `PSDF_ADDR_MEAS, {5'h00, 11'h4B6, 2'h0, 14'd14745});
		$display("reset test done");
	endtask
	task automatic t_update();
		repeat (300) @(posedge clk);
		// Temperature still holds the start-up result of the reset value
		fetch_chk(4, PSDF_ST_FRESH, 14'd14745, 11'h000);
		$display("update test done");
	endtask
	// Counter of pressure-only cycles must reach 255, then a full one clears it
	task automatic t_cycle();
		logic [7:0] mx;
		mx = 8'h00;
		for (int k = 0; k < 6000 && !(mx == 8'hFF && q[11:4] == 8'h00); k++)
		begin
			bus(1'b0, `PSDF_ADDR_STAT, 32'h0);
			if (q[11:4] > mx)
				mx = q[11:4];
		end
		check(32'(mx), 32'hFF);
		check(32'(q[11:4]), 32'h0);
		$display("cycle test done");
	endtask
	task automatic t_pdown();
		int e[4] = '{PRESS + 1, PRESS + PD1, PRESS + PD2, PRESS + PD3};
		longint t0, t1;
		int d;
		for (int s = 0; s < 4; s++)
		begin
			bus(1'b1, `PSDF_ADDR_CTRL, 32'(s << 1));
			wait_cnt(t0);
			wait_cnt(t0);
			wait_cnt(t1);
			d = int'((t1 - t0) / 20);
			check({31'h0, d >= e[s] - 3 && d <= e[s] + 6}, 32'h1);
		end
		$display("power-down test done");
	endtask
	task automatic t_sleep();
		bus(1'b1, `PSDF_ADDR_CTRL, 32'h1);
		repeat (400) @(posedge clk);
		fetch(1'b1, 2);
		fetch_chk(3, PSDF_ST_STALE, 14'd14745, 11'h4B6);
		bus(1'b1, `PSDF_ADDR_MEAS, {5'h00, 11'h123, 2'h0, 14'd1638});
		fetch(1'b0, 0);
		fetch_chk(2, PSDF_ST_FRESH, 14'd1638, 11'h4B6);
		// Stale first bit leaves the data line free for the stop
		fetch(1'b1, 0);
		fetch_chk(2, PSDF_ST_STALE, 14'd1638, 11'h4B6);
		repeat (200) @(posedge clk);
		fetch_chk(4, PSDF_ST_FRESH, 14'd1638, 11'h123);
		fetch_chk(2, PSDF_ST_STALE, 14'd1638, 11'h123);
		bus(1'b1, `PSDF_ADDR_MEAS, {5'h00, 11'h7FF, 2'h0, 14'h2D3C});
		fetch(1'b0, 0);
		repeat (100) @(posedge clk);
		fetch_chk(4, PSDF_ST_FRESH, 14'h2D3C, 11'h123);
		$display("sleep test done");
	endtask
	task automatic t_status();
		bus(1'b1, `PSDF_ADDR_CTRL, 32'hFFFF_FFFF);
		bus(1'b0, `PSDF_ADDR_CTRL, 32'h0);
		check(q, `PSDF_CTRL_MASK);
		fetch_chk(2, PSDF_ST_INVALID, 14'h2D3C, 11'h123);
		bus(1'b1, `PSDF_ADDR_CTRL, 32'h9);
		fetch_chk(2, PSDF_ST_DIAG, 14'h2D3C, 11'h123);
		bus(1'b1, `PSDF_ADDR_CTRL, 32'h1);
		fetch_chk(2, PSDF_ST_STALE, 14'h2D3C, 11'h123);
		$display("status test done");
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Watchdog well beyond the expected run of about 16000 cycles
	initial
	begin
		#(60000 * 20);
		error_cnt++;
		finish_test();
	end
	initial
	begin
		{arst_n, rd, wr, addr, wdata, be} = {1'b0, 2'b00, 4'h0, 32'h0, 4'hF};
		error_cnt = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_update();
		t_cycle();
		t_pdown();
		t_sleep();
		t_status();
		finish_test();
	end
endmodule
bind psdf_top psdf_checker u_psdf_checker (.clk(clk), .arst_n(arst_n),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
